// ---- design/mctf_pkg.sv ----
package mctf_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 4;
  localparam logic [15:0] PSC_RESET = 16'h0000;
  localparam logic [15:0] ARR_RESET = 16'hffff;
  localparam logic [7:0] DT_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    MCTF_DIR_UP,
    MCTF_DIR_DOWN,
    MCTF_DIR_UPDOWN
  } mctf_count_mode_type;

  typedef enum logic [2:0] {
    MCTF_CH_OFF,
    MCTF_CH_CAPTURE,
    MCTF_CH_COMPARE,
    MCTF_CH_PWM_EDGE,
    MCTF_CH_PWM_CENTER,
    MCTF_CH_ONE_PULSE
  } mctf_ch_mode_type;

  typedef enum logic [1:0] {
    MCTF_CLK_INTERNAL,
    MCTF_CLK_ENCODER,
    MCTF_CLK_HALL
  } mctf_clk_src_type;

  typedef struct packed {
    logic                enable;
    mctf_count_mode_type count_mode;
    mctf_clk_src_type    clk_src;
    logic [15:0]         prescale;
    logic [15:0]         reload;
    logic                debug_freeze;
    logic                trig_start;
    logic                trig_reset;
    logic [7:0]          dead_time;
  } mctf_cfg_type;
endpackage

// ---- design/mctf_timer.sv ----
`timescale 1ns/10ps
module mctf_timer #(
  parameter int  NUM_CH    = mctf_pkg::NUM_CH,
  parameter bit  UP_ONLY   = 1'b0,
  parameter bit  HAS_COMPL = 1'b1
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // configuration
  input  wire mctf_pkg::mctf_cfg_type cfg,
  input  wire mctf_pkg::mctf_ch_mode_type [3:0] ch_mode,
  input  wire logic [3:0][15:0]     ch_compare,
  input  wire logic                 update_flag_clr,
  input  wire logic [3:0]           capture_flag_clr,
  // system
  input  wire logic                 debug_halt,
  input  wire logic                 trig_in,
  // pins
  input  wire logic [3:0]           ch_in,
  input  wire logic [2:0]           hall_in,
  // status
  output logic [15:0]               count_q,
  output logic                      update_flag_q,
  output logic [3:0]                capture_flag_q,
  output logic [3:0][15:0]          capture_q,
  output logic                      trig_out_q,
  output logic                      dac_trig_q,
  output logic                      dma_req_q,
  output logic [3:0]                ch_out_q,
  output logic [3:0]                ch_out_n_q
);
  logic [3:0] in_s1_q, in_s2_q, in_s3_q;
  logic [2:0] hall_s1_q, hall_s2_q, hall_s3_q;
  logic       trig_s1_q, trig_s2_q, trig_s3_q;
  logic [15:0] psc_q;
  logic       down_q, running_q;
  logic [3:0] raw_q, raw_d, opm_done_q;
  logic [3:0][7:0] dt_q;
  logic       tick, upd, quad_step, quad_dir, hall_chg, trig_rise;
  logic [15:0] reload;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_s1_q   <= '0;
      in_s2_q   <= '0;
      in_s3_q   <= '0;
      hall_s1_q <= '0;
      hall_s2_q <= '0;
      hall_s3_q <= '0;
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      in_s1_q   <= ch_in;
      in_s2_q   <= in_s1_q;
      in_s3_q   <= in_s2_q;
      hall_s1_q <= hall_in;
      hall_s2_q <= hall_s1_q;
      hall_s3_q <= hall_s2_q;
      trig_s1_q <= trig_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign reload = cfg.reload;
  // channel 1/2 inputs act as quadrature A/B in encoder mode
  assign quad_step = (in_s2_q[0] ^ in_s3_q[0]) | (in_s2_q[1] ^ in_s3_q[1]);
  // quad_dir high means count up: phase A leading phase B
  assign quad_dir  = (in_s2_q[0] ^ in_s3_q[0]) ? (in_s2_q[0] != in_s2_q[1])
                                                : (in_s2_q[1] == in_s2_q[0]);
  assign hall_chg  = |(hall_s2_q ^ hall_s3_q);
  assign trig_rise = trig_s2_q & ~trig_s3_q;

  // run control: external trigger may start the counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) running_q <= 1'b0;
    else running_q <= cfg.enable & (running_q | ~cfg.trig_start | trig_rise);
  end

  always_comb begin
    case (cfg.clk_src)
      mctf_pkg::MCTF_CLK_ENCODER: tick = quad_step;
      mctf_pkg::MCTF_CLK_HALL:    tick = hall_chg;
      // >= so lowering the prescale mid-period cannot stall the counter
      default:                    tick = (psc_q >= cfg.prescale);
    endcase
    tick = tick & running_q & ~(debug_halt & cfg.debug_freeze);
  end

  // prescaler divides by prescale+1, so 1..65536
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) psc_q <= mctf_pkg::PSC_RESET;
    else if (!running_q || (psc_q >= cfg.prescale)) psc_q <= '0;
    else if (!(debug_halt & cfg.debug_freeze)) psc_q <= psc_q + 16'h0001;
  end

  logic dn;
  always_comb begin
    if (cfg.clk_src == mctf_pkg::MCTF_CLK_ENCODER) dn = ~quad_dir & ~UP_ONLY;
    else dn = down_q & ~UP_ONLY;
  end
  assign upd = tick & (dn ? (count_q == 16'h0000) : (count_q >= reload));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= mctf_pkg::CNT_RESET;
      down_q  <= 1'b0;
    end else if (cfg.enable && trig_rise && cfg.trig_reset) begin
      // also on the starting trigger, so a started timer begins in step with its master
      count_q <= '0;
      down_q  <= 1'b0;
    end else if (tick && cfg.clk_src == mctf_pkg::MCTF_CLK_ENCODER) begin
      // direction follows the phase order, not the count mode
      down_q  <= dn;
      if (dn) count_q <= (count_q == 16'h0000) ? reload : count_q - 16'h0001;
      else count_q <= (count_q >= reload) ? '0 : count_q + 16'h0001;
    end else if (tick) begin
      case (UP_ONLY ? mctf_pkg::MCTF_DIR_UP : cfg.count_mode)
        mctf_pkg::MCTF_DIR_DOWN: begin
          down_q  <= 1'b1;
          count_q <= (count_q == 16'h0000) ? reload : count_q - 16'h0001;
        end
        mctf_pkg::MCTF_DIR_UPDOWN: begin
          if (!down_q && count_q >= reload) begin
            down_q  <= 1'b1;
            count_q <= count_q - 16'h0001;
          end else if (down_q && count_q == 16'h0000) begin
            down_q  <= 1'b0;
            count_q <= 16'h0001;
          end else count_q <= down_q ? count_q - 16'h0001 : count_q + 16'h0001;
        end
        default: begin
          down_q  <= 1'b0;
          count_q <= (count_q >= reload) ? '0 : count_q + 16'h0001;
        end
      endcase
    end
  end

  // update event feeds trigger link, DAC trigger and DMA request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_out_q    <= 1'b0;
      dac_trig_q    <= 1'b0;
      dma_req_q     <= 1'b0;
      update_flag_q <= 1'b0;
    end else begin
      trig_out_q <= upd;
      dac_trig_q <= upd;
      dma_req_q  <= upd;
      update_flag_q <= upd | (update_flag_q & ~update_flag_clr);
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_ch
    if (i < NUM_CH) begin : g_on
      logic cap_ev;
      assign cap_ev = (ch_mode[i] == mctf_pkg::MCTF_CH_CAPTURE) & in_s2_q[i] & ~in_s3_q[i];
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          capture_q[i]      <= '0;
          capture_flag_q[i] <= 1'b0;
        end else begin
          if (cap_ev) capture_q[i] <= count_q;
          capture_flag_q[i] <= cap_ev | (capture_flag_q[i] & ~capture_flag_clr[i]);
        end
      end
      // compare >= reload+1 gives fully on, 0 gives fully off
      always_comb begin
        case (ch_mode[i])
          mctf_pkg::MCTF_CH_PWM_EDGE, mctf_pkg::MCTF_CH_PWM_CENTER:
            raw_d[i] = (count_q < ch_compare[i]);
          mctf_pkg::MCTF_CH_COMPARE:
            raw_d[i] = (tick && count_q == ch_compare[i]) ? ~raw_q[i] : raw_q[i];
          mctf_pkg::MCTF_CH_ONE_PULSE:
            raw_d[i] = ~opm_done_q[i] & (count_q >= ch_compare[i]);
          default: raw_d[i] = 1'b0;
        endcase
      end
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          raw_q[i]      <= 1'b0;
          opm_done_q[i] <= 1'b0;
          dt_q[i]       <= '0;
          ch_out_q[i]   <= 1'b0;
          ch_out_n_q[i] <= 1'b0;
        end else begin
          raw_q[i] <= raw_d[i];
          if (ch_mode[i] != mctf_pkg::MCTF_CH_ONE_PULSE) opm_done_q[i] <= 1'b0;
          else if (upd && !dn) opm_done_q[i] <= 1'b1;
          // dead time: both sides low until the delay after each edge
          if (raw_d[i] != raw_q[i]) dt_q[i] <= cfg.dead_time;
          else if (dt_q[i] != 8'h00) dt_q[i] <= dt_q[i] - 8'h01;
          // both sides read raw_q, so the pair can never be high together
          ch_out_q[i]   <= raw_q[i] & (dt_q[i] == 8'h00);
          ch_out_n_q[i] <= HAS_COMPL & ~raw_q[i] & (dt_q[i] == 8'h00)
                           & (ch_mode[i] != mctf_pkg::MCTF_CH_OFF);
        end
      end
    end else begin : g_off
      assign raw_d[i] = 1'b0;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          capture_q[i] <= '0; capture_flag_q[i] <= 1'b0; raw_q[i] <= 1'b0;
          opm_done_q[i] <= 1'b0; dt_q[i] <= '0; ch_out_q[i] <= 1'b0; ch_out_n_q[i] <= 1'b0;
        end else begin
          capture_q[i] <= '0; capture_flag_q[i] <= 1'b0; raw_q[i] <= 1'b0;
          opm_done_q[i] <= 1'b0; dt_q[i] <= '0; ch_out_q[i] <= 1'b0; ch_out_n_q[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- testbench/mctf_pins.sv ----
`timescale 1ns/10ps
module mctf_pins (
  // bench control
  input  wire logic  clk,
  input  wire logic  enc_on,
  input  wire logic  enc_rev,
  input  wire logic  hall_on,
  // pins toward the timer
  output logic [3:0] ch_in,
  output logic [2:0] hall_in
);
  logic [1:0]  dv = 2'h0;
  logic [1:0]  ph = 2'h0;
  logic [2:0]  hs = 3'h0;
  logic [17:0] tbl = 18'b001_011_010_110_100_101;
  // one step per four cycles so each level outlasts the input synchroniser
  always @(posedge clk) begin
    dv <= dv + 2'h1;
    if (enc_on && dv == 2'h0) ph <= enc_rev ? ph - 2'h1 : ph + 2'h1;
    if (hall_on && dv == 2'h0) hs <= (hs == 3'h5) ? 3'h0 : hs + 3'h1;
  end
  // gray codes: one line changes per step, like real sensors
  assign ch_in = {2'h0, ph[1], ph[1] ^ ph[0]};
  assign hall_in = tbl[3 * (5 - int'(hs)) +: 3];
endmodule

// ---- testbench/mctf_timer_properties.sv ----
`timescale 1ns/10ps
module mctf_timer_properties (
  // clock and reset
  input wire logic                             clk,
  input wire logic                             reset_n,
  // controls
  input wire mctf_pkg::mctf_cfg_type           cfg,
  input wire mctf_pkg::mctf_ch_mode_type [3:0] ch_mode,
  input wire logic [3:0][15:0]                 ch_compare,
  input wire logic                             update_flag_clr,
  input wire logic                             debug_halt,
  // results
  input wire logic [15:0]                      count_q,
  input wire logic                             update_flag_q,
  input wire logic                             trig_out_q,
  input wire logic                             dac_trig_q,
  input wire logic                             dma_req_q,
  input wire logic [3:0]                       ch_out_q,
  input wire logic [3:0]                       ch_out_n_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_frozen;
    debug_halt && cfg.debug_freeze && !cfg.trig_reset;
  endsequence
  sequence s_up_run;
    $past(reset_n) && $past(cfg.enable) && cfg.enable && cfg.prescale == 16'h0
      && cfg.count_mode == mctf_pkg::MCTF_DIR_UP && cfg.clk_src == mctf_pkg::MCTF_CLK_INTERNAL
      && !cfg.trig_start && !cfg.trig_reset && !debug_halt && count_q < cfg.reload;
  endsequence
  a_freeze_holds: assert property (s_frozen |=> $stable(count_q))
    else $error("count moved while frozen");
  a_up_step: assert property (s_up_run |=> count_q == $past(count_q) + 16'h1)
    else $error("up count did not step by one");
  a_pulses_together: assert property (dma_req_q == trig_out_q && dac_trig_q == trig_out_q)
    else $error("update pulses differ");
  a_pulse_sets_flag: assert property (trig_out_q |-> update_flag_q)
    else $error("update pulse without flag");
  a_flag_sticky: assert property (update_flag_q && !update_flag_clr |=> update_flag_q)
    else $error("flag dropped without clear");
  a_duty_zero: assert property ((ch_mode[0] == mctf_pkg::MCTF_CH_PWM_EDGE
    && ch_compare[0] == 16'h0) [*3] |-> !ch_out_q[0]) else $error("zero duty output high");
  a_duty_full: assert property ((ch_mode[1] == mctf_pkg::MCTF_CH_PWM_EDGE
    && ch_compare[1] > cfg.reload && count_q <= cfg.reload && cfg.dead_time < 8'h4) [*8]
    |-> ch_out_q[1]) else $error("full duty output low");
  a_never_both: assert property ((ch_out_q & ch_out_n_q) == 4'h0)
    else $error("output pair high together");
endmodule
bind mctf_timer mctf_timer_properties u_props (.clk, .reset_n, .cfg, .ch_mode, .ch_compare,
  .update_flag_clr, .debug_halt, .count_q, .update_flag_q, .trig_out_q, .dac_trig_q,
  .dma_req_q, .ch_out_q, .ch_out_n_q);

// ---- testbench/mctf_timer_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
module mctf_timer_tb_top;
  logic                             clk = 1'b0, reset_n = 1'b0;
  mctf_pkg::mctf_cfg_type           cfg = '0;
  mctf_pkg::mctf_ch_mode_type [3:0] ch_mode = '{default: mctf_pkg::MCTF_CH_OFF};
  logic [3:0][15:0]                 ch_compare = '0;
  logic                             update_flag_clr = 1'b0, debug_halt = 1'b0, trig_in = 1'b0;
  logic                             enc_on = 1'b0, enc_rev = 1'b0, hall_on = 1'b0;
  logic                             update_flag_q, trig_out_q;
  logic [3:0]                       ch_in, ch_out_q, ch_out_n_q;
  logic [2:0]                       hall_in;
  logic [3:0]                       cap_flag;
  logic [3:0][15:0]                 cap_val;
  logic [15:0]                      count_q, st;
  logic [7:0]                       hi, lo;
  int                               failures = 0, num_checks = 0, cyc = 0, e, seed = 32'h048b77f6;
  int                               exp_q[$];
  always #5 clk = ~clk;
  mctf_pins u_pins (.clk(clk), .enc_on(enc_on), .enc_rev(enc_rev), .hall_on(hall_on),
    .ch_in(ch_in), .hall_in(hall_in));
  mctf_timer #(.NUM_CH(4), .UP_ONLY(1'b0), .HAS_COMPL(1'b1)) DUT (.clk(clk), .reset_n(reset_n),
    .cfg(cfg), .ch_mode(ch_mode), .ch_compare(ch_compare), .update_flag_clr(update_flag_clr),
    .capture_flag_clr(4'h0), .debug_halt(debug_halt), .trig_in(trig_in), .ch_in(ch_in),
    .hall_in(hall_in), .count_q(count_q), .update_flag_q(update_flag_q),
    .capture_flag_q(cap_flag), .capture_q(cap_val), .trig_out_q(trig_out_q), .dac_trig_q(),
    .dma_req_q(), .ch_out_q(ch_out_q),
    .ch_out_n_q(ch_out_n_q));
  // period between update pulses against the oldest note
  always @(posedge clk) begin
    if (trig_out_q === 1'b1) begin
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        `CHK(cyc, e)
      end
      cyc = 1;
    end else cyc++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_until(input int what);
    int k;
    for (k = 0; k < 3000; k++) begin
      tick(1);
      if (what == 0 && trig_out_q === 1'b1) break;
      if (what == 1 && exp_q.size() == 0) break;
    end
    if (k == 3000) begin
      failures++;
      results();
    end
  endtask
  task automatic run_case(input mctf_pkg::mctf_count_mode_type m, input int r, input int p);
    cfg.count_mode = m;
    cfg.reload = 16'(r);
    cfg.prescale = 16'(p);
    wait_until(0);
    wait_until(0);
    tick(1);
    repeat (2) exp_q.push_back((m == mctf_pkg::MCTF_DIR_UPDOWN ? r : r + 1) * (p + 1));
    wait_until(1);
    $display("period test done, mode %0d", m);
  endtask
  initial begin
    tick(5);
    reset_n = 1'b1;
    cfg.enable = 1'b1;
    run_case(mctf_pkg::MCTF_DIR_UP, 2, 0);
    for (int m = 0; m < 3; m++) run_case(mctf_pkg::mctf_count_mode_type'(m),
      2 + ($random(seed) & 7), $random(seed) & 3);
    cfg.enable = 1'b0;
    tick(3);
    `CHK(update_flag_q, 1'b1)
    update_flag_clr = 1'b1;
    tick(1);
    update_flag_clr = 1'b0;
    tick(1);
    `CHK(update_flag_q, 1'b0)
    cfg.enable = 1'b1;
    cfg.reload = 16'hffff;
    cfg.count_mode = mctf_pkg::MCTF_DIR_UP;
    cfg.prescale = 16'h0;
    cfg.debug_freeze = 1'b1;
    debug_halt = 1'b1;
    tick(2);
    st = count_q;
    tick(20);
    `CHK(count_q, st)
    debug_halt = 1'b0;
    tick(5);
    `CHK(count_q != st, 1'b1)
    cfg.enable = 1'b0;
    tick(1);
    cfg.trig_start = 1'b1;
    cfg.trig_reset = 1'b1;
    cfg.enable = 1'b1;
    tick(10);
    // the tick already under way when enable fell still lands
    `CHK(count_q, st + 16'h6)
    trig_in = 1'b1;
    tick(8);
    trig_in = 1'b0;
    // zeroed on the synced edge, then five ticks
    `CHK(count_q, 16'h5)
    cfg.trig_start = 1'b0;
    cfg.trig_reset = 1'b0;
    $display("freeze and link test done");
    cfg.reload = 16'h9;
    cfg.dead_time = 8'h2;
    ch_mode = '{mctf_pkg::MCTF_CH_PWM_CENTER, mctf_pkg::MCTF_CH_PWM_EDGE,
      mctf_pkg::MCTF_CH_PWM_EDGE, mctf_pkg::MCTF_CH_PWM_EDGE};
    ch_compare = {16'h4, 16'h4, 16'ha, 16'h0};
    tick(30);
    hi = 8'h0;
    lo = 8'h0;
    repeat (10) begin
      tick(1);
      hi += ch_out_q[2];
      lo += ch_out_n_q[2];
    end
    `CHK(hi, 8'h2)
    `CHK(lo, 8'h4)
    for (int m = 0; m < 6; m++) begin
      ch_mode[3] = mctf_pkg::mctf_ch_mode_type'(m);
      tick(25);
    end
    $display("channel test done");
    cfg.reload = 16'hffff;
    cfg.clk_src = mctf_pkg::MCTF_CLK_HALL;
    tick(5);
    st = count_q;
    hall_on = 1'b1;
    tick(24);
    hall_on = 1'b0;
    tick(8);
    `CHK(count_q, st + 16'h6)
    cfg.clk_src = mctf_pkg::MCTF_CLK_ENCODER;
    ch_mode[0] = mctf_pkg::MCTF_CH_CAPTURE;
    for (int d = 0; d < 2; d++) begin
      tick(5);
      st = count_q;
      enc_rev = d[0];
      enc_on = 1'b1;
      tick(24);
      enc_on = 1'b0;
      tick(8);
      `CHK(d == 0 ? count_q > st : count_q < st, 1'b1)
      // phase A rises on the first and fifth forward step
      if (d == 0) begin
        `CHK(cap_flag[0], 1'b1)
        `CHK(cap_val[0], st + 16'h4)
      end
    end
    $display("sensor test done");
    results();
  end
endmodule
